// file: verilog/ssf_regs.svh
/*
 serial status flags: register offsets, field positions, reset values,
 buffer depth and widths. assumes inclusion by bare name from design files.
*/
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
// ========================================
// offsets
`define SSF_OFF_STATUS 12'h000
`define SSF_OFF_CTRL 12'h004
`define SSF_OFF_IRQ_STAT 12'h008
`define SSF_OFF_IRQ_MASK 12'h00C
`define SSF_OFF_RXDATA 12'h010
`define SSF_OFF_TXDATA 12'h014
// ========================================
// status fields
`define SSF_RXCNT_LSB 24
`define SSF_TXCNT_LSB 16
`define SSF_FRAMING_FAULT_BIT 12
`define SSF_BUSY_BIT 11
`define SSF_TUR_BIT 8
`define SSF_SHIFTER_EMPTY_BIT 7
`define SSF_ROV_BIT 6
`define SSF_RBE_BIT 5
`define SSF_TBE_BIT 3
`define SSF_TBF_BIT 1
`define SSF_RBF_BIT 0
// ========================================
// control fields
`define SSF_CTRL_ON_BIT 0
`define SSF_CTRL_ENH_BIT 1
`define SSF_CTRL_FRM_BIT 2
`define SSF_CTRL_RESET 32'h0000_0000
// ========================================
// irq status bits
`define SSF_IRQ_FRAMING_FAULT 0
`define SSF_IRQ_TUR 1
`define SSF_IRQ_ROV 2
`define SSF_IRQ_RXDONE 3
`define SSF_IRQ_WIDTH 4
// ========================================
// buffers and link
`define SSF_DEPTH 16
`define SSF_PTR_W 4
`define SSF_WORD_W 8
`define SSF_BIT_CNT_W 3
`endif

// file: verilog/ssf_pkg.sv
/*
 serial status flags package: shared types.
 assumes ssf_regs.svh for the numeric constants.
*/
package ssf_pkg;
   // ========================================
   // link pins as seen by the device
   typedef struct packed {
      logic sck;
      logic mosi;
      logic frame_n;
   } ssf_link_in_type;
   // ========================================
   // control bits
   typedef struct packed {
      logic framed_mode_enable;
      logic enhanced_buffer_mode;
      logic module_on;
   } ssf_ctrl_type;
endpackage

// file: verilog/ssf_sync.sv
/*
 two-flop synchroniser for link pins.
 assumes inputs asynchronous to clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ssf_sync (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [2:0] async_in,
   output logic [2:0] sync_out
);
   logic [2:0] first_reg;
   logic [2:0] first_next;
   logic [2:0] second_next;
   always_comb begin
      first_next = async_in;
      second_next = first_reg;
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         // rest at pin idle levels: sck low, mosi low, frame_n high
         first_reg <= 3'h1;
         sync_out <= 3'h1;
      end else begin
         first_reg <= first_next;
         sync_out <= second_next;
      end
   end
endmodule
`default_nettype wire

// file: verilog/ssf_fifo.sv
/*
 word store with pointers and count, flip-flop storage.
 assumes push is dropped by caller when full.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_fifo (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic push,
   input wire logic [`SSF_WORD_W-1:0] push_data,
   input wire logic pop,
   output logic [`SSF_WORD_W-1:0] head,
   output logic [`SSF_PTR_W:0] count,
   output logic [`SSF_PTR_W-1:0] rd_ptr,
   output logic [`SSF_PTR_W-1:0] wr_ptr
);
   logic [`SSF_WORD_W-1:0] mem_reg [`SSF_DEPTH];
   logic [`SSF_PTR_W-1:0] rd_next;
   logic [`SSF_PTR_W-1:0] wr_next;
   logic [`SSF_PTR_W:0] count_next;
   logic do_push;
   logic do_pop;
   always_comb begin
      do_push = push && (count != 5'(`SSF_DEPTH));
      do_pop = pop && (count != 5'h00);
      rd_next = rd_ptr;
      wr_next = wr_ptr;
      count_next = count;
      if (clear) begin
         rd_next = 4'h0;
         wr_next = 4'h0;
         count_next = 5'h00;
      end else begin
         if (do_push) wr_next = wr_ptr + 4'h1;
         if (do_pop) rd_next = rd_ptr + 4'h1;
         if (do_push && !do_pop) count_next = count + 5'h01;
         if (do_pop && !do_push) count_next = count - 5'h01;
      end
      head = mem_reg[rd_ptr];
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr <= 4'h0;
         wr_ptr <= 4'h0;
         count <= 5'h00;
      end else begin
         rd_ptr <= rd_next;
         wr_ptr <= wr_next;
         count <= count_next;
      end
   end
   always_ff @(posedge clock) begin
      if (do_push && !clear) mem_reg[wr_ptr] <= push_data;
   end
endmodule
`default_nettype wire

// file: verilog/ssf_top.sv
/*
 serial status flags: spi slave link with status register over apb.
 assumes a link master driving sck, mosi and an active-low frame pin,
 sck far slower than clock; apb master per the usual protocol.
*/
// How it works
// - status bits 28-24 show the receive store occupancy, valid in enhanced mode.
// - status bits 20-16 show the transmit store occupancy, valid in enhanced mode.
// - a frame pulse arriving mid-word in framed mode sets the frame fault flag.
// - the frame fault flag is set by hardware, cleared by software writing zero to it, resets low.
// - the busy flag is high while a word is being shifted, low when idle.
// - in framed mode a word start with an empty transmit store sets underrun.
// - underrun clears on module off then on, or on software writing zero to it.
// - the shifter empty flag is one when no word is in the shift register.
// - a word arriving while the receive store is full is dropped and overflow set.
// - overflow is set by hardware, cleared by module off/on or writing zero.
// - receive empty is one when read and write pointers are equal and the receive store is not full.
// - unimplemented status bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ssf_pkg::ssf_link_in_type link_in,
   output logic miso,
   output logic irq
);
   import ssf_pkg::*;
   // ========================================
   // link synchroniser
   logic [2:0] pins_sync;
   logic sck_s;
   logic mosi_s;
   logic frame_s;
   ssf_sync u_sync (
      .clock(clock),
      .reset_n(reset_n),
      .async_in({link_in.sck, link_in.mosi, link_in.frame_n}),
      .sync_out(pins_sync)
   );
   always_comb begin
      sck_s = pins_sync[2];
      mosi_s = pins_sync[1];
      frame_s = !pins_sync[0];
   end
   // ========================================
   // state
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} ssf_link_state_type;
   ssf_link_state_type state_reg, state_next;
   ssf_ctrl_type ctrl_reg, ctrl_next;
   logic sck_d_reg, sck_d_next;
   logic frame_d_reg, frame_d_next;
   logic [`SSF_WORD_W-1:0] rx_sh_reg, rx_sh_next;
   logic [`SSF_WORD_W-1:0] tx_sh_reg, tx_sh_next;
   logic [`SSF_BIT_CNT_W-1:0] bits_reg, bits_next;
   logic framing_fault_reg, framing_fault_next;
   logic tx_underrun_reg, tx_underrun_next;
   logic rx_overflow_reg, rx_overflow_next;
   logic [`SSF_IRQ_WIDTH-1:0] irq_stat_reg, irq_stat_next;
   logic [`SSF_IRQ_WIDTH-1:0] irq_mask_reg, irq_mask_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next, miso_next, irq_next;
   logic [`SSF_IRQ_WIDTH-1:0] events;
   // ========================================
   // stores
   logic rx_push, rx_pop, tx_push, tx_pop, store_clear;
   logic [`SSF_WORD_W-1:0] rx_head, tx_head;
   logic [`SSF_PTR_W:0] rx_elem_count, tx_elem_count;
   logic [`SSF_PTR_W-1:0] rx_read_pointer, rx_write_pointer;
   ssf_fifo u_rx (
      .clock(clock),
      .reset_n(reset_n),
      .clear(store_clear),
      .push(rx_push),
      .push_data(rx_sh_next),
      .pop(rx_pop),
      .head(rx_head),
      .count(rx_elem_count),
      .rd_ptr(rx_read_pointer),
      .wr_ptr(rx_write_pointer)
   );
   ssf_fifo u_tx (
      .clock(clock),
      .reset_n(reset_n),
      .clear(store_clear),
      .push(tx_push),
      .push_data(pwdata[`SSF_WORD_W-1:0]),
      .pop(tx_pop),
      .head(tx_head),
      .count(tx_elem_count),
      .rd_ptr(),
      .wr_ptr()
   );
   // ========================================
   // helpers
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction
   logic [`SSF_PTR_W:0] rx_cap;
   logic tx_full;
   logic rx_full;
   logic tx_empty;
   logic rx_empty;
   logic link_active;
   logic shifter_empty;
   logic [31:0] status_word;
   logic wr_acc, rd_acc, sck_rise, sck_fall, frame_rise, word_done;
   always_comb begin
      rx_cap = ctrl_reg.enhanced_buffer_mode ? 5'(`SSF_DEPTH) : 5'h01;
      tx_full = tx_elem_count == rx_cap;
      rx_full = rx_elem_count == rx_cap;
      tx_empty = tx_elem_count == 5'h00;
      rx_empty = rx_read_pointer == rx_write_pointer && !rx_full;
      link_active = state_reg == ST_SHIFT;
      shifter_empty = !link_active;
      status_word = 32'h0000_0000;
      status_word[`SSF_RXCNT_LSB +: 5] = rx_elem_count;
      status_word[`SSF_TXCNT_LSB +: 5] = tx_elem_count;
      status_word[`SSF_FRAMING_FAULT_BIT] = framing_fault_reg;
      status_word[`SSF_BUSY_BIT] = link_active;
      status_word[`SSF_TUR_BIT] = tx_underrun_reg;
      status_word[`SSF_SHIFTER_EMPTY_BIT] = shifter_empty;
      status_word[`SSF_ROV_BIT] = rx_overflow_reg;
      status_word[`SSF_RBE_BIT] = rx_empty;
      status_word[`SSF_TBE_BIT] = tx_empty;
      status_word[`SSF_TBF_BIT] = tx_full;
      status_word[`SSF_RBF_BIT] = rx_full;
   end
   // ========================================
   // link engine
   always_comb begin
      sck_d_next = sck_s;
      frame_d_next = frame_s;
      sck_rise = sck_s && !sck_d_reg;
      sck_fall = !sck_s && sck_d_reg;
      frame_rise = frame_s && !frame_d_reg;
      state_next = state_reg;
      rx_sh_next = rx_sh_reg;
      tx_sh_next = tx_sh_reg;
      bits_next = bits_reg;
      word_done = 1'b0;
      tx_pop = 1'b0;
      events = '0;
      if (!ctrl_reg.module_on) begin
         state_next = ST_IDLE;
         bits_next = 3'h0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (ctrl_reg.framed_mode_enable ? frame_rise : sck_rise) begin
                  state_next = ST_SHIFT;
                  bits_next = 3'h0;
                  tx_pop = !tx_empty;
                  tx_sh_next = tx_empty ? 8'h00 : tx_head;
                  if (ctrl_reg.framed_mode_enable && tx_empty)
                     events[`SSF_IRQ_TUR] = 1'b1;
                  if (!ctrl_reg.framed_mode_enable) begin
                     rx_sh_next = {7'h00, mosi_s};
                     bits_next = 3'h1;
                  end
               end
            end
            ST_SHIFT: begin
               if (ctrl_reg.framed_mode_enable && frame_rise && bits_reg != 3'h0)
                  events[`SSF_IRQ_FRAMING_FAULT] = 1'b1;
               if (sck_fall)
                  tx_sh_next = {tx_sh_reg[6:0], 1'b0};
               if (sck_rise) begin
                  rx_sh_next = {rx_sh_reg[6:0], mosi_s};
                  bits_next = bits_reg + 3'h1;
                  if (bits_reg == 3'h7) begin
                     word_done = 1'b1;
                     state_next = ST_IDLE;
                  end
               end
            end
         endcase
      end
      if (word_done && rx_full)
         events[`SSF_IRQ_ROV] = 1'b1;
      if (word_done && !rx_full)
         events[`SSF_IRQ_RXDONE] = 1'b1;
      rx_push = word_done && !rx_full;
      miso_next = tx_sh_reg[`SSF_WORD_W-1];
   end
   // ========================================
   // apb slave, flags, interrupts
   always_comb begin
      wr_acc = psel && penable && pwrite;
      rd_acc = psel && !penable && !pwrite;
      ctrl_next = ctrl_reg;
      irq_mask_next = irq_mask_reg;
      framing_fault_next = framing_fault_reg;
      tx_underrun_next = tx_underrun_reg;
      rx_overflow_next = rx_overflow_reg;
      irq_stat_next = irq_stat_reg;
      tx_push = 1'b0;
      rx_pop = 1'b0;
      store_clear = 1'b0;
      pready_next = psel && !penable;
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      if (psel && !penable) begin
         unique case (1'b1)
            hit(paddr, `SSF_OFF_STATUS): prdata_next = status_word;
            hit(paddr, `SSF_OFF_CTRL): prdata_next = {29'h0, ctrl_reg};
            hit(paddr, `SSF_OFF_IRQ_STAT): prdata_next = {28'h0, irq_stat_reg};
            hit(paddr, `SSF_OFF_IRQ_MASK): prdata_next = {28'h0, irq_mask_reg};
            hit(paddr, `SSF_OFF_RXDATA): prdata_next = {24'h0, rx_head};
            hit(paddr, `SSF_OFF_TXDATA): prdata_next = 32'h0000_0000;
            default: pslverr_next = 1'b1;
         endcase
      end
      if (rd_acc && hit(paddr, `SSF_OFF_RXDATA))
         rx_pop = 1'b1;
      if (wr_acc) begin
         if (hit(paddr, `SSF_OFF_CTRL)) begin
            ctrl_next = ssf_ctrl_type'(pwdata[2:0]);
            if (ctrl_reg.module_on && !pwdata[`SSF_CTRL_ON_BIT]) begin
               tx_underrun_next = 1'b0;
               rx_overflow_next = 1'b0;
               store_clear = 1'b1;
            end
         end
         if (hit(paddr, `SSF_OFF_STATUS)) begin
            if (!pwdata[`SSF_FRAMING_FAULT_BIT]) framing_fault_next = 1'b0;
            if (!pwdata[`SSF_TUR_BIT]) tx_underrun_next = 1'b0;
            if (!pwdata[`SSF_ROV_BIT]) rx_overflow_next = 1'b0;
         end
         if (hit(paddr, `SSF_OFF_IRQ_STAT))
            irq_stat_next = irq_stat_reg & ~pwdata[`SSF_IRQ_WIDTH-1:0];
         if (hit(paddr, `SSF_OFF_IRQ_MASK))
            irq_mask_next = pwdata[`SSF_IRQ_WIDTH-1:0];
         if (hit(paddr, `SSF_OFF_TXDATA) && !tx_full)
            tx_push = 1'b1;
      end
      // hardware set wins over clear
      if (events[`SSF_IRQ_FRAMING_FAULT]) framing_fault_next = 1'b1;
      if (events[`SSF_IRQ_TUR]) tx_underrun_next = 1'b1;
      if (events[`SSF_IRQ_ROV]) rx_overflow_next = 1'b1;
      irq_stat_next = irq_stat_next | events;
      irq_next = |(irq_stat_next & irq_mask_next);
   end
   // ========================================
   // registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         ctrl_reg <= ssf_ctrl_type'(3'h0);
         sck_d_reg <= 1'b0;
         frame_d_reg <= 1'b0;
         rx_sh_reg <= 8'h00;
         tx_sh_reg <= 8'h00;
         bits_reg <= 3'h0;
         framing_fault_reg <= 1'b0;
         tx_underrun_reg <= 1'b0;
         rx_overflow_reg <= 1'b0;
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         miso <= 1'b0;
         irq <= 1'b0;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         sck_d_reg <= sck_d_next;
         frame_d_reg <= frame_d_next;
         rx_sh_reg <= rx_sh_next;
         tx_sh_reg <= tx_sh_next;
         bits_reg <= bits_next;
         framing_fault_reg <= framing_fault_next;
         tx_underrun_reg <= tx_underrun_next;
         rx_overflow_reg <= rx_overflow_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         miso <= miso_next;
         irq <= irq_next;
      end
   end
endmodule
`default_nettype wire

// file: dv/ssf_top_monitor.sv
/*
 checker for ssf_top: status read fields, sticky flags, bus answers.
 assumes binding to ssf_top and its port names.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_top_monitor (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire ssf_pkg::ssf_link_in_type link_in,
   input wire logic miso,
   input wire logic irq
);
   import ssf_pkg::*;
   logic rd_st;
   logic [2:0] seen_reg;
   logic [2:0] seen_next;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // ========================================
   // sticky flags seen since the last write
   assign rd_st = psel && penable && !pwrite && pready
      && paddr == `SSF_OFF_STATUS;
   always_comb begin
      seen_next = seen_reg;
      if (psel && penable && pwrite) begin
         seen_next = 3'h0;
      end else if (rd_st) begin
         seen_next = seen_reg | {prdata[12], prdata[8], prdata[6]};
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         seen_reg <= 3'h0;
      end else begin
         seen_reg <= seen_next;
      end
   end
   // ========================================
   // properties
   property p_rsvd;
      rd_st |-> prdata[31:29] == 3'h0 && prdata[23:21] == 3'h0
         && prdata[15:13] == 3'h0 && prdata[10:9] == 2'h0
         && !prdata[4] && !prdata[2];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("unused status bit set");
   property p_cnt;
      rd_st |-> prdata[28:24] <= 5'h10 && prdata[20:16] <= 5'h10;
   endproperty
   a_cnt: assert property (p_cnt)
      else $error("count beyond depth");
   property p_rbe;
      rd_st |-> prdata[5] == (prdata[28:24] == 5'h00);
   endproperty
   a_rbe: assert property (p_rbe)
      else $error("rx empty disagrees with count");
   property p_tbe;
      rd_st |-> prdata[3] == (prdata[20:16] == 5'h00);
   endproperty
   a_tbe: assert property (p_tbe)
      else $error("tx empty disagrees with count");
   property p_full;
      rd_st |-> !(prdata[5] && prdata[0]) && !(prdata[3] && prdata[1]);
   endproperty
   a_full: assert property (p_full)
      else $error("empty and full together");
   property p_ferr;
      rd_st && seen_reg[2] |-> prdata[12];
   endproperty
   a_ferr: assert property (p_ferr)
      else $error("frame fault lost without write");
   property p_tur;
      rd_st && seen_reg[1] |-> prdata[8];
   endproperty
   a_tur: assert property (p_tur)
      else $error("underrun lost without write");
   property p_rov;
      rd_st && seen_reg[0] |-> prdata[6];
   endproperty
   a_rov: assert property (p_rov)
      else $error("overflow lost without write");
   sequence s_bad_setup;
      psel && !penable && !pwrite && paddr >= 12'h018;
   endsequence
   property p_unmapped;
      s_bad_setup |=> pready && pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read answered wrongly");
   c_rov: cover property (rd_st && prdata[6]);
   c_ferr: cover property (rd_st && prdata[12]);
   c_busy: cover property (rd_st && prdata[11]);
endmodule
bind ssf_top ssf_top_monitor u_mon (
   .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .link_in(link_in), .miso(miso),
   .irq(irq)
);
`default_nettype wire

// file: dv/ssf_link_master.sv
/*
 link master model: sck, mosi, frame pulse; mode 0, msb first.
 assumes a 160 ns sck period; sck rests low between bursts.
*/
`timescale 1ns/1ns
`default_nettype none
module ssf_link_master (
   output var ssf_pkg::ssf_link_in_type link,
   input wire logic miso
);
   import ssf_pkg::*;
   initial begin
      link = '{sck: 1'b0, mosi: 1'b0, frame_n: 1'b1};
   end
   // ========================================
   // n bits of d, optional frame pulse first
   task automatic send(input logic [7:0] d, input bit fr, input int n,
      output logic [7:0] got);
      got = 8'h00;
      #3;
      if (fr) begin
         link.frame_n = 1'b0;
         #80;
         link.frame_n = 1'b1;
      end
      for (int i = 0; i < n; i++) begin
         link.mosi = d[7 - i];
         #40;
         link.sck = 1'b1;
         got = {got[6:0], miso};
         #80;
         link.sck = 1'b0;
         #40;
      end
      link.mosi = ~link.mosi;
   endtask
endmodule
`default_nettype wire

// file: dv/ssf_top_bench.sv
/*
 testbench for ssf_top: apb tasks, link bursts, status checks.
 assumes ssf_link_master and the checker bound to ssf_top.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssf_regs.svh"
module ssf_top_bench;
   import ssf_pkg::*;
   localparam logic [11:0] st = `SSF_OFF_STATUS;
   localparam logic [11:0] ct = `SSF_OFF_CTRL;
   localparam logic [11:0] ist = `SSF_OFF_IRQ_STAT;
   localparam logic [11:0] msk = `SSF_OFF_IRQ_MASK;
   localparam logic [11:0] rxd = `SSF_OFF_RXDATA;
   localparam logic [11:0] txd = `SSF_OFF_TXDATA;
   localparam logic [31:0] f32 = 32'hFFFF_FFFF;
   logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
   logic miso, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] got;
   ssf_link_in_type link_in;
   int fails, num_checks, cycles;
   ssf_top u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_in(link_in), .miso(miso), .irq(irq));
   ssf_link_master u_master (.link(link_in), .miso(miso));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ========================================
   // tasks
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] v);
      num_checks++;
      if (v !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic rc(input logic [11:0] a, input string s,
      input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(s, e & m, rd & m);
   endtask
   task automatic xfer(input logic [7:0] d, input bit fr, input int n);
      u_master.send(d, fr, n, got);
      repeat (8) @(posedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   // ========================================
   // main sequence
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fails = 0;
      num_checks = 0;
      cycles = 0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      rc(st, "reset status", 32'h0000_00A8, f32);
      apb(1'b1, st, f32);
      rc(st, "status after write", 32'h0000_00A8, f32);
      rc(12'h020, "unmapped data", 32'h0, f32);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, ct, 32'h3);
      apb(1'b1, txd, 32'h3C);
      rc(st, "tx count", 32'h0001_00A0, f32);
      xfer(8'hA5, 1'b0, 8);
      chk("miso word", 32'h3C, {24'h0, got});
      rc(st, "rx count", 32'h0100_0088, f32);
      rc(rxd, "rx data", 32'hA5, 32'hFF);
      rc(st, "drained", 32'h0000_00A8, f32);
      xfer(8'h96, 1'b0, 4);
      rc(st, "busy mid word", 32'h800, 32'h980);
      xfer(8'h60, 1'b0, 4);
      rc(st, "idle after word", 32'h80, 32'h880);
      rc(rxd, "split word", 32'h96, 32'hFF);
      $display("test enhanced done");
      apb(1'b1, ct, 32'h1);
      apb(1'b1, msk, 32'h4);
      xfer(8'h11, 1'b0, 8);
      xfer(8'h22, 1'b0, 8);
      rc(st, "overflow set", 32'h41, 32'h41);
      chk("irq raised", 32'h1, {31'h0, irq});
      rc(rxd, "kept word", 32'h11, 32'hFF);
      rc(st, "overflow held", 32'h40, 32'h41);
      apb(1'b1, st, 32'h0);
      rc(st, "overflow written", 32'h0, 32'h40);
      apb(1'b1, ist, 32'hF);
      rc(ist, "irq status", 32'h0, 32'h4);
      chk("irq cleared", 32'h0, {31'h0, irq});
      xfer(8'h33, 1'b0, 8);
      xfer(8'h44, 1'b0, 8);
      apb(1'b1, ct, 32'h0);
      apb(1'b1, ct, 32'h1);
      rc(st, "overflow off on", 32'h0, 32'h40);
      $display("test overflow done");
      apb(1'b1, msk, 32'h0);
      apb(1'b1, ct, 32'h7);
      xfer(8'h5A, 1'b1, 8);
      chk("zeros shifted", 32'h0, {24'h0, got});
      rc(st, "underrun", 32'h100, 32'h1100);
      xfer(8'h5A, 1'b1, 3);
      xfer(8'hC3, 1'b1, 8);
      rc(st, "frame fault", 32'h1100, 32'h1100);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, st, 32'h0);
      rc(st, "flags written", 32'h0, 32'h1100);
      xfer(8'h5A, 1'b1, 8);
      apb(1'b1, ct, 32'h0);
      apb(1'b1, ct, 32'h7);
      rc(st, "underrun off on", 32'h0, 32'h100);
      $display("test framed done");
      give_verdict();
   end
endmodule
`default_nettype wire
